// ==== verilog/drf_defs.svh ====
// timing constants, credit limits and the burst length bit for the refresh / self-refresh link
`ifndef DRF_DEFS_SVH
`define DRF_DEFS_SVH
// clock period in ns (25 MHz)
`define DRF_CLK_NS 40
// refresh interval in ns, rounded down to whole cycles
`define DRF_TREFI_NS 7800
`define DRF_TREFI_CYC ((`DRF_TREFI_NS) / (`DRF_CLK_NS))
// minimum refresh cycle time in ns, rounded up
`define DRF_TRFC_NS 260
`define DRF_TRFC_CYC (((`DRF_TRFC_NS) + (`DRF_CLK_NS) - 1) / (`DRF_CLK_NS))
// minimum precharge time in ns, rounded up
`define DRF_TRP_NS 14
`define DRF_TRP_CYC (((`DRF_TRP_NS) + (`DRF_CLK_NS) - 1) / (`DRF_CLK_NS))
// minimum cke hold / self-refresh residency in ns, rounded up
`define DRF_TCKE_NS 5
`define DRF_TCKE_CYC (((`DRF_TCKE_NS) + (`DRF_CLK_NS) - 1) / (`DRF_CLK_NS))
// self-refresh exit to non-dll command in ns, rounded up
`define DRF_TXS_NS 270
`define DRF_TXS_CYC (((`DRF_TXS_NS) + (`DRF_CLK_NS) - 1) / (`DRF_CLK_NS))
// self-refresh exit to dll command, in clock cycles
`define DRF_TXSDLL_CYC 512
// odt latency plus margin before self-refresh entry, in cycles
`define DRF_ODT_OFF_CYC 8
// refresh credit limits
`define DRF_MAX_POSTPONE 8
`define DRF_MAX_PULLIN 8
// burst length selector bit within the address
`define DRF_BL_BIT 12
// minimum spacing between column commands, in clock cycles
`define DRF_TCCD_CYC 4
`endif

// ==== verilog/drf_pkg.sv ====
// types shared by both ends of the refresh link
package drf_pkg;
   // decoded command on the bus (cs, ras, cas, we)
   typedef enum logic [3:0] {
      DRF_CMD_REF = 4'h1,
      DRF_CMD_NOP = 4'h7,
      DRF_CMD_DES = 4'h8,
      DRF_CMD_RD = 4'h5,
      DRF_CMD_WR = 4'h4,
      DRF_CMD_PRE = 4'h2
   } drf_cmd_t;
endpackage : drf_pkg

// ==== verilog/drf_link_if.sv ====
// command, clock-enable and odt wires between controller and memory
`timescale 1ns/1ps
`default_nettype none
interface drf_link_if;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic cke;
   logic odt;
   logic [15:0] addr;
   logic ref_busy;
   logic self_ref;
   logic dll_on;
   modport ctl (output cs_n, ras_n, cas_n, we_n, cke, odt, addr, input ref_busy, self_ref, dll_on);
   modport mem (input cs_n, ras_n, cas_n, we_n, cke, odt, addr, output ref_busy, self_ref, dll_on);
endinterface : drf_link_if
`default_nettype wire

// ==== verilog/drf_cnt.sv ====
// loadable down counter used for every timing window except the refresh interval
`timescale 1ns/1ps
`default_nettype none
module drf_cnt #(
   parameter int W = 10
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // load strobe and value
   input wire logic load_in,
   input wire logic [W-1:0] val_in,
   // zero flag
   output logic zero_out
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   // load wins, otherwise count to zero and stop
   always_comb
   begin
      cnt_d = cnt_q;
      if (load_in)
         cnt_d = val_in;
      else if (cnt_q != '0)
         cnt_d = cnt_q - 1'b1;
   end
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end
   assign zero_out = (cnt_q == '0);
endmodule : drf_cnt
`default_nettype wire

// ==== verilog/drf_mem.sv ====
// memory end: refresh decode, internal row counter, self-refresh with dll control
`timescale 1ns/1ps
`default_nettype none
`include "drf_defs.svh"
module drf_mem
   import drf_pkg::*;
#(
   parameter int ROW_W = 16
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // link to controller
   drf_link_if.mem link,
   // user side status
   output logic [ROW_W-1:0] ref_row_out,
   output logic ref_pulse_out,
   output logic bc4_out,
   output logic burst_valid_out
);
   typedef enum logic [1:0] {
      DRF_M_IDLE = 2'b00,
      DRF_M_REF = 2'b01,
      DRF_M_SREF = 2'b10
   } drf_mstate_t;
   drf_mstate_t st_q, st_d;
   logic [ROW_W-1:0] row_q, row_d;      // internal refresh row counter
   logic pulse_q, pulse_d;
   logic bc4_q, bc4_d;
   logic bv_q, bv_d;
   logic dll_q, dll_d;                  // dll enabled
   logic cke_q;                         // previous cke, for edge decode
   logic busy_q, busy_d;
   logic load;
   logic [9:0] load_val;
   logic tmr_zero;
   logic [3:0] cmd;
   assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
   // one timer covers tRFC in refresh and tCKE in self-refresh
   drf_cnt #(.W(10)) u_tmr (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .load_in(load),
      .val_in(load_val),
      .zero_out(tmr_zero)
   );
   // next state of the memory sequencer
   always_comb
   begin
      st_d = st_q;
      row_d = row_q;
      pulse_d = 1'b0;
      bc4_d = bc4_q;
      bv_d = 1'b0;
      dll_d = dll_q;
      busy_d = busy_q;
      load = 1'b0;
      load_val = 10'h000;
      case (st_q)
         DRF_M_IDLE:
         begin
            busy_d = 1'b0;
            if (cmd == DRF_CMD_REF && cke_q)
            begin
               // address pins ignored, row from counter
               row_d = row_q + 1'b1;
               pulse_d = 1'b1;
               load = 1'b1;
               busy_d = 1'b1;
               if (!link.cke)
               begin
                  st_d = DRF_M_SREF;
                  dll_d = 1'b0;
                  load_val = 10'(`DRF_TCKE_CYC);
               end
               else
               begin
                  st_d = DRF_M_REF;
                  load_val = 10'(`DRF_TRFC_CYC);
               end
            end
            else if (link.cke && (cmd == DRF_CMD_RD || cmd == DRF_CMD_WR))
            begin
               // a12 is burst length only, never a column bit
               bc4_d = !link.addr[`DRF_BL_BIT];
               bv_d = 1'b1;
               // write timing faults only corrupt that location; no hang state exists
            end
         end
         DRF_M_REF:
         begin
            // commands are ignored until tRFC elapses
            if (tmr_zero)
            begin
               st_d = DRF_M_IDLE;
               busy_d = 1'b0;
            end
         end
         DRF_M_SREF:
         begin
            // only cke is looked at here
            if (tmr_zero && busy_q)
            begin
               // internal refresh issued within tCKE of entry
               row_d = row_q + 1'b1;
               pulse_d = 1'b1;
               busy_d = 1'b0;
            end
            if (link.cke && !busy_q)
            begin
               st_d = DRF_M_IDLE;
               dll_d = 1'b1;
            end
         end
         default:
            st_d = DRF_M_IDLE;
      endcase
   end
   // state registers
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         st_q <= DRF_M_IDLE;
         row_q <= '0;
         pulse_q <= 1'b0;
         bc4_q <= 1'b0;
         bv_q <= 1'b0;
         dll_q <= 1'b1;
         busy_q <= 1'b0;
         cke_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         row_q <= row_d;
         pulse_q <= pulse_d;
         bc4_q <= bc4_d;
         bv_q <= bv_d;
         dll_q <= dll_d;
         busy_q <= busy_d;
         cke_q <= link.cke;
      end
   end
   assign link.ref_busy = busy_q;
   assign link.self_ref = (st_q == DRF_M_SREF);
   assign link.dll_on = dll_q;
   assign ref_row_out = row_q;
   assign ref_pulse_out = pulse_q;
   assign bc4_out = bc4_q;
   assign burst_valid_out = bv_q;
endmodule : drf_mem
`default_nettype wire

// ==== verilog/drf_ctl.sv ====
// controller end: refresh credit scheduling and self-refresh entry / exit
`timescale 1ns/1ps
`default_nettype none
`include "drf_defs.svh"
module drf_ctl
   import drf_pkg::*;
#(
   parameter int TREFI = `DRF_TREFI_CYC,
   parameter int TXSDLL = `DRF_TXSDLL_CYC
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // user requests
   input wire logic sr_req_in,
   input wire logic busy_in,
   // link to memory
   drf_link_if.ctl link,
   // status
   output logic in_sr_out,
   output logic ready_out
);
   typedef enum logic [2:0] {
      DRF_C_RUN = 3'b000,
      DRF_C_REFW = 3'b001,
      DRF_C_ODT = 3'b010,
      DRF_C_SR = 3'b011,
      DRF_C_XS = 3'b100,
      DRF_C_XREF = 3'b101
   } drf_cstate_t;
   drf_cstate_t st_q, st_d;
   logic signed [4:0] cred_q, cred_d;   // positive = owed refreshes
   logic [12:0] tick_q, tick_d;
   logic [3:0] cmd_q, cmd_d;
   logic cke_q, cke_d;
   logic sr_q, sr_d;
   logic rdy_q, rdy_d;
   logic xref_q, xref_d;                // extra refresh done since exit
   logic [3:0] gapt_q, gapt_d;          // refresh intervals since the last refresh
   logic [15:0] addr_q, addr_d;         // command address; only the burst length bit matters
   logic bl8_q, bl8_d;                  // burst length asked on the next read
   logic load;
   logic [9:0] load_val;
   logic tz;
   logic tick;
   drf_cnt #(.W(10)) u_tmr (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .load_in(load),
      .val_in(load_val),
      .zero_out(tz)
   );
   assign tick = (tick_q == 13'(TREFI - 1));
   // next state: credit, refresh issue and self-refresh flow
   always_comb
   begin
      st_d = st_q;
      cred_d = cred_q;
      tick_d = tick ? 13'h0000 : tick_q + 13'h0001;
      cmd_d = DRF_CMD_NOP;
      cke_d = cke_q;
      sr_d = sr_q;
      rdy_d = 1'b0;
      xref_d = xref_q;
      gapt_d = gapt_q;
      addr_d = 16'h0000;
      bl8_d = bl8_q;
      load = 1'b0;
      load_val = 10'h000;
      // one refresh owed per interval, clipped at the postpone limit
      if (tick && cred_q < 5'sd`DRF_MAX_POSTPONE)
         cred_d = cred_q + 5'sd1;
      // credit alone would let pulled-in plus postponed refreshes stretch the gap; count it too
      if (tick && gapt_q != 4'hF)
         gapt_d = gapt_q + 4'h1;
      case (st_q)
         DRF_C_RUN:
         begin
            rdy_d = !busy_in;
            // refresh when owed and idle, or forced at the limit, or pulled in
            if (tz && (cred_q >= 5'sd`DRF_MAX_POSTPONE || gapt_q >= 4'(`DRF_MAX_POSTPONE) ||
                (cred_q > 5'sd0 && !busy_in) || (!busy_in && cred_q > -5'sd`DRF_MAX_PULLIN) ||
                (sr_req_in && cred_q > 5'sd0)))
            begin
               cmd_d = DRF_CMD_REF;
               // a pulled-in refresh beyond the limit earns no further credit
               if (cred_d > -5'sd`DRF_MAX_PULLIN)
                  cred_d = cred_d - 5'sd1;
               gapt_d = 4'h0;
               xref_d = 1'b1;
               rdy_d = 1'b0;
               load = 1'b1;
               load_val = 10'(`DRF_TRFC_CYC + `DRF_TRP_CYC);
               st_d = DRF_C_REFW;
            end
            else if (sr_req_in && tz && cred_q <= 5'sd0 && xref_q)
            begin
               // odt is held low already; sit out its latency before entry
               load = 1'b1;
               load_val = 10'(`DRF_ODT_OFF_CYC);
               rdy_d = 1'b0;
               st_d = DRF_C_ODT;
            end
            else if (tz && busy_in && !sr_req_in)
            begin
               // user read; a12 alternates chop of four and eight, reads spaced by tCCD
               cmd_d = DRF_CMD_RD;
               addr_d[`DRF_BL_BIT] = bl8_q;
               bl8_d = !bl8_q;
               load = 1'b1;
               load_val = 10'(`DRF_TCCD_CYC);
            end
         end
         DRF_C_REFW:
            // nop only until tRFC and tRP are both met
            if (tz)
               st_d = DRF_C_RUN;
         DRF_C_ODT:
            if (tz)
            begin
               cmd_d = DRF_CMD_REF;
               cke_d = 1'b0;
               sr_d = 1'b1;
               xref_d = 1'b0;
               load = 1'b1;
               load_val = 10'(`DRF_TCKE_CYC + 1);
               st_d = DRF_C_SR;
            end
         DRF_C_SR:
         begin
            cred_d = 5'sd0; // device refreshes itself while asleep
            gapt_d = 4'h0;
            if (tz && !sr_req_in)
            begin
               cke_d = 1'b1;
               load = 1'b1;
               load_val = 10'(TXSDLL);
               st_d = DRF_C_XS;
            end
         end
         DRF_C_XS:
         begin
            // cke high, odt low, nop only for the exit window
            if (tz)
            begin
               sr_d = 1'b0;
               st_d = DRF_C_RUN;
            end
         end
         default:
            st_d = DRF_C_RUN;
      endcase
   end
   // registers
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         st_q <= DRF_C_RUN;
         cred_q <= 5'sd0;
         tick_q <= 13'h0000;
         cmd_q <= DRF_CMD_NOP;
         cke_q <= 1'b1;
         sr_q <= 1'b0;
         rdy_q <= 1'b0;
         xref_q <= 1'b0;
         gapt_q <= 4'h0;
         addr_q <= 16'h0000;
         bl8_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         cred_q <= cred_d;
         tick_q <= tick_d;
         cmd_q <= cmd_d;
         cke_q <= cke_d;
         sr_q <= sr_d;
         rdy_q <= rdy_d;
         xref_q <= xref_d;
         gapt_q <= gapt_d;
         addr_q <= addr_d;
         bl8_q <= bl8_d;
      end
   end
   assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd_q;
   assign link.cke = cke_q;
   assign link.odt = 1'b0;
   assign link.addr = addr_q;
   assign in_sr_out = sr_q;
   assign ready_out = rdy_q;
endmodule : drf_ctl
`default_nettype wire

// ==== dv/drf_assertions.sv ====
// concurrent checks on the command link between controller and memory
`timescale 1ns/1ps
`default_nettype none
`include "drf_defs.svh"
module drf_assertions #(
   parameter int TREFI = 20
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // command and clock enable from the controller
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic cke,
   input wire logic odt,
   input wire logic [15:0] addr,
   // status from the memory
   input wire logic ref_busy,
   input wire logic self_ref,
   input wire logic dll_on
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // longest legal awake gap between refreshes
   localparam int GAP_MAX = 9 * TREFI;
   // command decodes
   logic cmd_ref;
   logic cmd_idle;
   assign cmd_ref = !cs_n && !ras_n && !cas_n && we_n;
   assign cmd_idle = cs_n || (ras_n && cas_n && we_n);
   logic cmd_rd;
   assign cmd_rd = !cs_n && ras_n && !cas_n && we_n;
   // cycles since last refresh; cleared while asleep
   logic [15:0] gap_q;
   logic [15:0] gap_d;
   // a refresh followed the last wake-up; set at reset so first entry is legal
   logic seen_q;
   logic seen_d;
   logic cke_q;
   // next state of the helper counters
   always_comb
   begin
      gap_d = gap_q + 16'h0001;
      seen_d = seen_q;
      if (cmd_ref || self_ref || !cke)
      begin
         gap_d = 16'h0000;
      end
      if (cmd_ref && cke && cke_q)
      begin
         seen_d = 1'b1;
      end
      else if (cke && !cke_q)
      begin
         seen_d = 1'b0;
      end
   end
   // helper registers
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         gap_q <= 16'h0000;
         seen_q <= 1'b1;
         cke_q <= 1'b1;
      end
      else
      begin
         gap_q <= gap_d;
         seen_q <= seen_d;
         cke_q <= cke;
      end
   end
   a_ref_starts_busy: assert property (cmd_ref && cke && cke_q && !ref_busy |=> ref_busy)
      else $error("refresh not taken");
   a_ref_busy_span: assert property ($rose(ref_busy) && !self_ref |-> ref_busy [*8] ##1 !ref_busy)
      else $error("refresh busy span wrong");
   a_ref_quiet_bus: assert property (cmd_ref && cke && cke_q |=> cmd_idle [*6])
      else $error("command inside refresh cycle");
   a_sr_entry_taken: assert property (cmd_ref && !cke && cke_q |-> ##[1:2] self_ref)
      else $error("self refresh not entered");
   a_sr_cke_low: assert property ($rose(self_ref) |-> !cke [*2])
      else $error("clock enable rose too soon");
   a_dll_sleeps: assert property ($rose(self_ref) |-> ##[0:1] !dll_on)
      else $error("dll still on in self refresh");
   a_dll_wakes: assert property ($fell(self_ref) |-> ##[0:16] dll_on)
      else $error("dll not back after exit");
   a_exit_nop: assert property ($rose(cke) |-> cmd_idle [*7])
      else $error("command during exit interval");
   a_exit_cke_high: assert property ($rose(cke) |-> cke [*8])
      else $error("clock enable dropped after exit");
   a_odt_quiet: assert property (self_ref || !cke |-> !odt)
      else $error("termination on in self refresh");
   a_ref_gap: assert property (gap_q <= GAP_MAX)
      else $error("refresh gap too long");
   a_reentry_ref: assert property (cmd_ref && !cke && cke_q |-> seen_q)
      else $error("no refresh before re-entry");
   a_ccd_space: assert property (cmd_rd |=> !cmd_rd [*3])
      else $error("reads closer than the chop spacing");
   a_sr_inner_ref: assert property ($rose(self_ref) |-> ##[1:2] !ref_busy)
      else $error("no internal refresh after entry");
   c_ref: cover property (cmd_ref && cke && cke_q);
   c_sr_entry: cover property ($rose(self_ref));
   c_sr_exit: cover property ($rose(cke));
   c_bc4_read: cover property (cmd_rd && !addr[`DRF_BL_BIT]);
endmodule : drf_assertions
`default_nettype wire

// ==== dv/tb_ddr3_refresh_self_refresh.sv ====
// self-checking bench joining controller and memory ends
`timescale 1ns/1ps
`default_nettype none
module tb_ddr3_refresh_self_refresh import drf_pkg::*;;
   // short counts keep the run brief
   localparam int TREFI = 20;
   localparam int TXSDLL = 16;
   // clock, reset and user requests
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic sr_req = 1'b0;
   logic busy = 1'b0;
   // observed outputs
   logic [15:0] ref_row;
   logic ref_pulse;
   logic in_sr;
   logic ready;
   logic bc4;
   logic burst_valid;
   // bookkeeping
   int error_cnt = 0;
   int checked = 0;
   int pulses = 0;
   int sr_pulses = 0;
   int bus_refs = 0;
   int awake = 0;
   int gap = 0;
   int max_gap = 0;
   int bc4_seen = 0;
   int bl8_seen = 0;
   drf_link_if u_drf_link_if ();
   drf_ctl #(.TREFI(TREFI), .TXSDLL(TXSDLL)) u_drf_ctl (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .sr_req_in(sr_req), .busy_in(busy), .link(u_drf_link_if.ctl), .in_sr_out(in_sr), .ready_out(ready));
   drf_mem u_drf_mem (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(u_drf_link_if.mem),
      .ref_row_out(ref_row), .ref_pulse_out(ref_pulse), .bc4_out(bc4), .burst_valid_out(burst_valid));
   drf_assertions #(.TREFI(TREFI)) u_drf_assertions (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .cs_n(u_drf_link_if.cs_n), .ras_n(u_drf_link_if.ras_n), .cas_n(u_drf_link_if.cas_n),
      .we_n(u_drf_link_if.we_n), .cke(u_drf_link_if.cke), .odt(u_drf_link_if.odt),
      .addr(u_drf_link_if.addr), .ref_busy(u_drf_link_if.ref_busy),
      .self_ref(u_drf_link_if.self_ref), .dll_on(u_drf_link_if.dll_on));
   // 25 MHz clock
   always #20 clk_in = ~clk_in;
   // counts refreshes and the longest awake gap; old values are seen at the edge
   always @(posedge clk_in)
   begin
      if (rst_n_in)
      begin
         if (ref_pulse === 1'b1) pulses++;
         if (ref_pulse === 1'b1 && u_drf_link_if.cke === 1'b0) sr_pulses++;
         if (u_drf_link_if.cke === 1'b1) awake++;
         if (burst_valid === 1'b1 && bc4 === 1'b1) bc4_seen++;
         if (burst_valid === 1'b1 && bc4 === 1'b0) bl8_seen++;
         if (u_drf_link_if.cke === 1'b1 && u_drf_link_if.cs_n === 1'b0 && u_drf_link_if.ras_n === 1'b0
            && u_drf_link_if.cas_n === 1'b0 && u_drf_link_if.we_n === 1'b1) bus_refs++;
         gap = (ref_pulse === 1'b1 || u_drf_link_if.cke !== 1'b1) ? 0 : gap + 1;
         if (gap > max_gap) max_gap = gap;
      end
   end
   // compares one value and counts it
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   // prints the counts and the verdict, then stops
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict
   // asks for self refresh and waits for it under a bound
   task automatic enter_sr();
      int n;
      int p0;
      n = 0;
      p0 = sr_pulses;
      sr_req = 1'b1;
      while (in_sr !== 1'b1 && n < 600)
      begin
         @(negedge clk_in);
         n++;
      end
      check(32'(in_sr), 32'h1);
      // the memory takes the entry one edge after the controller flags it
      @(negedge clk_in);
      check(32'(u_drf_link_if.dll_on), 32'h0);
      check(32'(u_drf_link_if.odt), 32'h0);
      repeat (30) @(negedge clk_in);
      // the entry itself is one pulse; the internal refresh must add another
      check(32'(sr_pulses - p0 >= 2), 32'h1);
   endtask : enter_sr
   // leaves self refresh; the controller must sit out the dll wait
   task automatic leave_sr();
      int n;
      n = 0;
      sr_req = 1'b0;
      while (u_drf_link_if.cke !== 1'b1 && n < 100)
      begin
         @(negedge clk_in);
         n++;
      end
      check(32'(u_drf_link_if.cke), 32'h1);
      check(32'(ready), 32'h0);
      n = 0;
      while (in_sr !== 1'b0 && n < 600)
      begin
         @(negedge clk_in);
         n++;
      end
      check(32'(n >= TXSDLL - 1), 32'h1);
      check(32'(u_drf_link_if.dll_on), 32'h1);
   endtask : leave_sr
   // main sequence
   initial
   begin
      int refs0;
      repeat (5) @(negedge clk_in);
      rst_n_in = 1'b1;
      check(32'(ref_row), 32'h0);
      check(32'(u_drf_link_if.cke), 32'h1);
      $display("test reset done");
      // idle: refreshes keep the average rate and walk the row counter
      repeat (10 * TREFI) @(negedge clk_in);
      while (ref_pulse === 1'b1) @(negedge clk_in);
      check(32'(pulses >= 9), 32'h1);
      check(32'(ref_row), 32'(pulses[15:0]));
      $display("test idle refresh done");
      // heavy traffic: refreshes are postponed but never too long
      busy = 1'b1;
      refs0 = pulses;
      repeat (12 * TREFI) @(negedge clk_in);
      busy = 1'b0;
      check(32'(pulses > refs0), 32'h1);
      check(32'(max_gap <= 9 * TREFI), 32'h1);
      check(32'(bc4_seen > 0), 32'h1);
      check(32'(bl8_seen > 0), 32'h1);
      $display("test postponed refresh done");
      // self refresh only with every postponed refresh paid back
      enter_sr();
      check(32'((bus_refs + 1) * TREFI >= awake), 32'h1);
      leave_sr();
      $display("test self refresh done");
      // immediate re-entry needs an extra refresh first
      refs0 = bus_refs;
      enter_sr();
      check(32'(bus_refs > refs0), 32'h1);
      leave_sr();
      $display("test re-entry done");
      give_verdict();
   end
   // watchdog well beyond the expected run length
   initial
   begin
      repeat (20000) @(posedge clk_in);
      error_cnt++;
      give_verdict();
   end
endmodule : tb_ddr3_refresh_self_refresh
`default_nettype wire
